/* File: rtl/clkout_defines.svh */
// register map, field positions and reset values of the output gating and divider block
// assumes inclusion by bare name from the design files; definitions only
`ifndef CLKOUT_DEFINES_SVH
`define CLKOUT_DEFINES_SVH

`define OFS_OUTPUT_NINE_CONTROL 10'h0F9
`define OFS_OUTPUT_TEN_CONTROL 10'h0FA
`define OFS_OUTPUT_ELEVEN_CONTROL 10'h0FB
`define OFS_LOCK_GATED_ENABLE_LOW 10'h0FC
`define OFS_LOCK_GATED_ENABLE_HIGH 10'h0FD
`define OFS_DIVIDER_ZERO_CYCLES 10'h190
`define OFS_DIVIDER_ZERO_CONTROL 10'h191

`define RST_OUTPUT_CONTROL 8'h02
`define RST_LOCK_GATED_ENABLE 8'h00
`define RST_DIVIDER_ZERO_CYCLES 8'h77
`define RST_DIVIDER_ZERO_CONTROL 8'h00

`define BIT_OUTPUT_POWER_DOWN 0
`define FLD_LOW_CYCLES_MSB 7
`define FLD_LOW_CYCLES_LSB 4
`define FLD_HIGH_CYCLES_MSB 3
`define FLD_HIGH_CYCLES_LSB 0
`define BIT_DIVIDER_BYPASS 7
`define BIT_IGNORE_SYNC 6
`define BIT_FORCE_HIGH 5
`define BIT_START_HIGH 4
`define FLD_PHASE_MSB 3
`define FLD_PHASE_LSB 0
`define LOCK_HIGH_USED_BITS 4

`endif

/* File: rtl/clkout_pkg.sv */
// types shared by the output gating and divider block
// assumes nothing beyond a SystemVerilog compiler
package clkout_pkg;

  typedef enum logic [0:0]
  {
    PHASE_LOW = 1'b0,
    PHASE_HIGH = 1'b1
  } phase_t;

  typedef logic [7:0] reg_byte_t;

endpackage : clkout_pkg

/* File: rtl/lock_gated_enable.sv */
// enable of one clock output, gated by the current-source lock signal
// assumes the lock signal is a level from the lock-detect logic; no clock involved
`timescale 1ns/1ps
module lock_gated_enable
(
  input wire logic power_down,
  input wire logic gate_enable,
  input wire logic lock_signal,
  output logic enable
);

  // purely combinational so the gating acts without waiting for a clock edge
  assign enable = !power_down && (!gate_enable || lock_signal);

endmodule : lock_gated_enable

/* File: rtl/output_gating_channel_divider.sv */
// output enables with lock gating, three output control registers, first channel divider
// assumes a simple internal register port from the serial control port, one clock core_clk
`timescale 1ns/1ps
`include "clkout_defines.svh"
module output_gating_channel_divider
#(
  parameter int ADDR_W = 10,
  parameter int NUM_OUTPUTS = 12
)
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  input wire logic current_source_lock_signal,
  input wire logic [8:0] low_outputs_power_down,
  input wire logic sync_req,
  output logic [NUM_OUTPUTS-1:0] output_enable,
  output logic [NUM_OUTPUTS-1:0] output_hiz,
  output logic [7:0] output_nine_config,
  output logic [7:0] output_ten_config,
  output logic [7:0] output_eleven_config,
  output logic divider_zero_out
);

  clkout_pkg::reg_byte_t output_nine_control_reg;
  clkout_pkg::reg_byte_t output_ten_control_reg;
  clkout_pkg::reg_byte_t output_eleven_control_reg;
  clkout_pkg::reg_byte_t lock_gated_enable_low_reg;
  clkout_pkg::reg_byte_t lock_gated_enable_high_reg;
  clkout_pkg::reg_byte_t divider_zero_cycles_reg;
  clkout_pkg::reg_byte_t divider_zero_control_reg;
  clkout_pkg::reg_byte_t rdata_next;

  logic [NUM_OUTPUTS-1:0] power_down_vec;
  logic [NUM_OUTPUTS-1:0] gate_vec;

  logic [3:0] low_cycles;
  logic [3:0] high_cycles;
  logic [3:0] phase_offset;
  logic bypass;
  logic ignore_sync;
  logic force_high;
  logic start_high;
  logic sync_held;
  logic sync_forced;

  clkout_pkg::phase_t phase_reg;
  clkout_pkg::phase_t phase_next;
  clkout_pkg::phase_t start_phase;
  logic [4:0] count_reg;
  logic [4:0] count_next;
  logic div_q_reg;
  logic div_q_next;

  // register writes; partial writes are not possible, every write is a full byte
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      output_nine_control_reg <= `RST_OUTPUT_CONTROL;
      output_ten_control_reg <= `RST_OUTPUT_CONTROL;
      output_eleven_control_reg <= `RST_OUTPUT_CONTROL;
      lock_gated_enable_low_reg <= `RST_LOCK_GATED_ENABLE;
      lock_gated_enable_high_reg <= `RST_LOCK_GATED_ENABLE;
      divider_zero_cycles_reg <= `RST_DIVIDER_ZERO_CYCLES;
      divider_zero_control_reg <= `RST_DIVIDER_ZERO_CONTROL;
    end
    else if (reg_wr)
    begin
      case (reg_addr)
        `OFS_OUTPUT_NINE_CONTROL: output_nine_control_reg <= reg_wdata;
        `OFS_OUTPUT_TEN_CONTROL: output_ten_control_reg <= reg_wdata;
        `OFS_OUTPUT_ELEVEN_CONTROL: output_eleven_control_reg <= reg_wdata;
        `OFS_LOCK_GATED_ENABLE_LOW: lock_gated_enable_low_reg <= reg_wdata;
        // only four gate bits exist in the high register; the rest stay zero
        `OFS_LOCK_GATED_ENABLE_HIGH:
          lock_gated_enable_high_reg <= {4'h0, reg_wdata[`LOCK_HIGH_USED_BITS-1:0]};
        `OFS_DIVIDER_ZERO_CYCLES: divider_zero_cycles_reg <= reg_wdata;
        `OFS_DIVIDER_ZERO_CONTROL: divider_zero_control_reg <= reg_wdata;
        default: ;
      endcase
    end
  end

  // read mux; unmapped addresses read zero
  always_comb
  begin
    case (reg_addr)
      `OFS_OUTPUT_NINE_CONTROL: rdata_next = output_nine_control_reg;
      `OFS_OUTPUT_TEN_CONTROL: rdata_next = output_ten_control_reg;
      `OFS_OUTPUT_ELEVEN_CONTROL: rdata_next = output_eleven_control_reg;
      `OFS_LOCK_GATED_ENABLE_LOW: rdata_next = lock_gated_enable_low_reg;
      `OFS_LOCK_GATED_ENABLE_HIGH: rdata_next = lock_gated_enable_high_reg;
      `OFS_DIVIDER_ZERO_CYCLES: rdata_next = divider_zero_cycles_reg;
      `OFS_DIVIDER_ZERO_CONTROL: rdata_next = divider_zero_control_reg;
      default: rdata_next = 8'h00;
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      reg_rdata <= 8'h00;
      reg_rvalid <= 1'b0;
    end
    else
    begin
      reg_rvalid <= reg_rd;
      if (reg_rd)
      begin
        reg_rdata <= rdata_next;
      end
    end
  end

  assign output_nine_config = output_nine_control_reg;
  assign output_ten_config = output_ten_control_reg;
  assign output_eleven_config = output_eleven_control_reg;

  // outputs zero to eight take their power-down from control registers kept elsewhere
  assign power_down_vec = {output_eleven_control_reg[`BIT_OUTPUT_POWER_DOWN],
                           output_ten_control_reg[`BIT_OUTPUT_POWER_DOWN],
                           output_nine_control_reg[`BIT_OUTPUT_POWER_DOWN],
                           low_outputs_power_down};
  assign gate_vec = {lock_gated_enable_high_reg[`LOCK_HIGH_USED_BITS-1:0], lock_gated_enable_low_reg};

  generate
    for (genvar i = 0; i < NUM_OUTPUTS; i++)
    begin : g_out
      lock_gated_enable u_gate
      (
        .power_down(power_down_vec[i]),
        .gate_enable(gate_vec[i]),
        .lock_signal(current_source_lock_signal),
        .enable(output_enable[i])
      );
    end
  endgenerate

  assign output_hiz = ~output_enable;

  // divider fields
  assign low_cycles = divider_zero_cycles_reg[`FLD_LOW_CYCLES_MSB:`FLD_LOW_CYCLES_LSB];
  assign high_cycles = divider_zero_cycles_reg[`FLD_HIGH_CYCLES_MSB:`FLD_HIGH_CYCLES_LSB];
  assign bypass = divider_zero_control_reg[`BIT_DIVIDER_BYPASS];
  assign ignore_sync = divider_zero_control_reg[`BIT_IGNORE_SYNC];
  assign force_high = divider_zero_control_reg[`BIT_FORCE_HIGH];
  assign start_high = divider_zero_control_reg[`BIT_START_HIGH];
  assign phase_offset = divider_zero_control_reg[`FLD_PHASE_MSB:`FLD_PHASE_LSB];

  assign sync_held = sync_req && !ignore_sync;
  // with ignore-sync set and bypass clear, a sync request parks the output at the forced level
  assign sync_forced = sync_req && ignore_sync && !bypass;
  assign start_phase = start_high ? clkout_pkg::PHASE_HIGH : clkout_pkg::PHASE_LOW;

  // count_reg holds the remaining input cycles of the current phase minus one
  always_comb
  begin
    phase_next = phase_reg;
    count_next = count_reg;
    if (bypass)
    begin
      phase_next = phase_reg;
      count_next = count_reg;
    end
    else if (sync_held || sync_forced)
    begin
      // restart on release: first phase stretched by the phase offset
      phase_next = start_phase;
      count_next = (start_high ? {1'b0, high_cycles} : {1'b0, low_cycles}) + {1'b0, phase_offset};
    end
    else if (count_reg == 5'h00)
    begin
      if (phase_reg == clkout_pkg::PHASE_HIGH)
      begin
        phase_next = clkout_pkg::PHASE_LOW;
        count_next = {1'b0, low_cycles};
      end
      else
      begin
        phase_next = clkout_pkg::PHASE_HIGH;
        count_next = {1'b0, high_cycles};
      end
    end
    else
    begin
      count_next = count_reg - 5'h01;
    end
  end

  always_comb
  begin
    if (sync_forced)
    begin
      div_q_next = force_high;
    end
    else
    begin
      div_q_next = (phase_next == clkout_pkg::PHASE_HIGH);
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      phase_reg <= clkout_pkg::PHASE_LOW;
      count_reg <= {1'b0, 4'h7};
      div_q_reg <= 1'b0;
    end
    else
    begin
      phase_reg <= phase_next;
      count_reg <= count_next;
      div_q_reg <= div_q_next;
    end
  end

  // bypass hands the input clock through; a clock mux, not a data path
  assign divider_zero_out = bypass ? core_clk : div_q_reg;

endmodule : output_gating_channel_divider

/* File: bench/ogcd_checker.sv */
// assertions on the ports of output_gating_channel_divider
// assumes binding to that module; one clock core_clk, rst synchronous active high
`timescale 1ns/1ps
module ogcd_checker
#(
  parameter int ADDR_W = 10,
  parameter int NUM_OUTPUTS = 12
)
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid,
  input wire logic current_source_lock_signal,
  input wire logic [8:0] low_outputs_power_down,
  input wire logic [NUM_OUTPUTS-1:0] output_enable,
  input wire logic [NUM_OUTPUTS-1:0] output_hiz,
  input wire logic [7:0] output_nine_config,
  input wire logic [7:0] output_eleven_config,
  input wire logic [7:0] output_ten_config
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  property p_rv_on; reg_rd |=> reg_rvalid; endproperty
  a_rv_on: assert property (p_rv_on) else $error("read not answered");
  property p_rv_off; !reg_rd |=> !reg_rvalid; endproperty
  a_rv_off: assert property (p_rv_off) else $error("spurious read valid");
  property p_cfg9; reg_rd && reg_addr == 10'h0F9 |=> reg_rdata == $past(output_nine_config); endproperty
  a_cfg9: assert property (p_cfg9) else $error("output nine readback");
  property p_cfg11; reg_rd && reg_addr == 10'h0FB |=> reg_rdata == $past(output_eleven_config); endproperty
  a_cfg11: assert property (p_cfg11) else $error("output eleven readback");
  property p_unmap; reg_rd && reg_addr == 10'h0FE |=> reg_rdata == 8'h00; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  property p_lock; current_source_lock_signal |-> output_enable == {~output_eleven_config[0],
    ~output_ten_config[0], ~output_nine_config[0], ~low_outputs_power_down}; endproperty
  a_lock: assert property (p_lock) else $error("enable wrong with lock high");
  property p_pd; (output_enable[8:0] & low_outputs_power_down) == 9'h000; endproperty
  a_pd: assert property (p_pd) else $error("powered-down output enabled");
  property p_hiz; output_hiz == ~output_enable; endproperty
  a_hiz: assert property (p_hiz) else $error("hiz not inverse of enable");
endmodule : ogcd_checker

/* File: bench/tb_output_gating_channel_divider.sv */
// self-checking bench for output_gating_channel_divider
// assumes the design and clkout_defines.svh on the include path
`timescale 1ns/1ps
`include "clkout_defines.svh"
module tb_output_gating_channel_divider;
  logic core_clk = 0, rst = 1, reg_wr = 0, reg_rd = 0, lock = 0, sync_req = 0;
  logic [9:0] reg_addr = 10'h000;
  logic [7:0] reg_wdata = 8'h00;
  logic [8:0] pd = 9'h000;
  logic [7:0] rdata, c9, c10, c11;
  logic rvalid, dout;
  logic [11:0] en, hiz;
  int errors = 0, tests_run = 0;
  output_gating_channel_divider i_output_gating_channel_divider (.core_clk(core_clk), .rst(rst),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(rdata),
    .reg_rvalid(rvalid), .current_source_lock_signal(lock), .low_outputs_power_down(pd),
    .sync_req(sync_req), .output_enable(en), .output_hiz(hiz), .output_nine_config(c9),
    .output_ten_config(c10), .output_eleven_config(c11), .divider_zero_out(dout));
  initial forever #50 core_clk = ~core_clk;
  task end_of_test;
    if (errors == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : end_of_test
  task chk(input logic [11:0] got, input logic [11:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      errors++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task wr(input logic [9:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge core_clk);
    reg_wr = 1'b0;
    // one idle edge, so a following call never raises the strobe in the step that lowered it
    @(negedge core_clk);
  endtask : wr
  task rd(input logic [9:0] a, input logic [7:0] exp);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge core_clk);
    reg_rd = 1'b0;
    chk(rvalid, 1'b1);
    chk(rdata, exp);
    @(negedge core_clk);
  endtask : rd
  task hold(input logic exp, input int n);
    repeat (n) @(negedge core_clk) chk(dout, exp);
  endtask : hold
  // phases counted on falling edges, after skipping any partial phase
  task measure(input logic [7:0] cyc);
    int n;
    n = 0;
    while (dout !== 1'b0 && n < 64) @(negedge core_clk) n++;
    while (dout !== 1'b1 && n < 64) @(negedge core_clk) n++;
    n = 0;
    while (dout === 1'b1 && n < 64) @(negedge core_clk) n++;
    chk(n[11:0], cyc[3:0] + 12'h001);
    n = 0;
    while (dout === 1'b0 && n < 64) @(negedge core_clk) n++;
    chk(n[11:0], cyc[7:4] + 12'h001);
  endtask : measure
  task t_reset;
    rd(10'h0F9, `RST_OUTPUT_CONTROL);
    rd(10'h0FA, `RST_OUTPUT_CONTROL);
    rd(10'h0FB, `RST_OUTPUT_CONTROL);
    rd(10'h0FC, 8'h00);
    rd(10'h0FD, 8'h00);
    rd(10'h190, 8'h77);
    rd(10'h191, 8'h00);
    rd(10'h0FE, 8'h00);
    chk(en, 12'hFFF);
  endtask : t_reset
  task t_gate;
    logic [11:0] m;
    wr(10'h0FD, 8'hFF);
    rd(10'h0FD, 8'h0F);
    wr(10'h0FC, 8'hFF);
    chk(en, 12'h000);
    for (int i = 0; i < 12; i++)
    begin
      m = 12'h001 << i;
      wr(10'h0FC, m[7:0]);
      wr(10'h0FD, {4'h0, m[11:8]});
      chk(en, ~m);
    end
    lock = 1'b1; // software has selected current-source lock detect and the pin comparator
    #1 chk(en, 12'hFFF);
    @(negedge core_clk);
  endtask : t_gate
  task t_pd;
    wr(10'h0FA, 8'hA5);
    rd(10'h0FA, 8'hA5);
    wr(10'h0F9, 8'h03);
    pd = 9'h008;
    #1 chk(en, 12'h9F7);
    chk(hiz, 12'h608);
    lock = 1'b0;
    #1 chk(en, 12'h1F7);
    @(negedge core_clk);
    wr(10'h0FD, 8'h00);
    wr(10'h0FA, 8'h02);
    pd = 9'h000;
  endtask : t_pd
  task t_div;
    measure(8'h77);
    wr(10'h190, 8'h21);
    repeat (20) @(negedge core_clk);
    measure(8'h21);
    wr(10'h191, 8'h80);
    @(posedge core_clk) #25 chk(dout, 1'b1);
    @(negedge core_clk) #25 chk(dout, 1'b0);
    @(negedge core_clk);
  endtask : t_div
  task t_sync;
    int n;
    wr(10'h191, 8'h00);
    sync_req = 1'b1;
    repeat (2) @(negedge core_clk);
    hold(1'b0, 12);
    wr(10'h191, 8'h10);
    @(negedge core_clk);
    hold(1'b1, 12);
    wr(10'h191, 8'h60);
    @(negedge core_clk);
    hold(1'b1, 8);
    wr(10'h191, 8'h40);
    @(negedge core_clk);
    hold(1'b0, 8);
    // start low with a phase offset of three; the first low phase after release is stretched
    wr(10'h191, 8'h03);
    sync_req = 1'b0;
    n = 0;
    while (dout === 1'b0 && n < 64) @(negedge core_clk) n++;
    chk(n[11:0], 12'h002 + 12'h003 + 12'h001);
  endtask : t_sync
  initial
  begin
    repeat (5) @(negedge core_clk);
    rst = 1'b0;
    t_reset;
    t_gate;
    t_pd;
    t_div;
    t_sync;
    end_of_test;
  end
  initial
  begin
    #2000000;
    errors++;
    end_of_test;
  end
endmodule : tb_output_gating_channel_divider
bind output_gating_channel_divider ogcd_checker #(.ADDR_W(ADDR_W), .NUM_OUTPUTS(NUM_OUTPUTS)) i_ogcd_checker
  (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .reg_rvalid(reg_rvalid), .current_source_lock_signal(current_source_lock_signal),
  .low_outputs_power_down(low_outputs_power_down), .output_enable(output_enable), .output_hiz(output_hiz),
  .output_nine_config(output_nine_config), .output_eleven_config(output_eleven_config),
  .output_ten_config(output_ten_config));
